//--- design/fbtm_pkg.sv
package fbtm_pkg;

    // Host register port request.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } fbtm_req_s;

    // One float-mode subtract-cycle result set, four channels.
    typedef struct packed {
        logic             valid;
        logic             slot_b;
        logic [3:0][13:0] result;
    } fbtm_sample_s;

    typedef logic [4:0] fbtm_count_t;

endpackage : fbtm_pkg

//--- design/fbtm_regs.svh
`ifndef FBTM_REGS_SVH
`define FBTM_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FBTM_STATUS_OFS   8'h04
`define FBTM_CFG_A_OFS    8'h16
`define FBTM_CFG_B_OFS    8'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FBTM_FLAGS_A_LSB  0
`define FBTM_FLAGS_A_MSB  3
`define FBTM_FLAGS_B_LSB  4
`define FBTM_FLAGS_B_MSB  7
`define FBTM_LIMIT_MSB    13
`define FBTM_TARGET_LSB   14
`define FBTM_TARGET_MSB   15

// ----------------------------------------------------------------
// Reset values and exceedance targets
// ----------------------------------------------------------------
`define FBTM_STATUS_RST   16'h0000
`define FBTM_CFG_A_RST    16'h0000
`define FBTM_CFG_B_RST    16'h0000
`define FBTM_TGT_NEVER    5'h00
`define FBTM_TGT_ONE      5'h01
`define FBTM_TGT_FOUR     5'h04
`define FBTM_TGT_SIXTEEN  5'h10

`endif

//--- design/fbtm_top.sv
`timescale 1ns/1ps
`include "fbtm_regs.svh"

// Functional notes
// - Slot B channel flag sets after its selected number of exceedances.
// - Slot B flags sit in status bits 7 to 4, channel 1 lowest.
// - Reading the status register clears the slot B flags.
// - Slot A channel flag sets after its selected number of exceedances.
// - Slot A flags sit in status bits 3 to 0, channel 1 lowest.
// - Reading the status register clears the slot A flags.
// - Slot A target code: 0 never, 1 once, 2 four, 3 sixteen.
// - Slot A result above the 14-bit limit counts one exceedance.
// - Slot B target code: 0 never, 1 once, 2 four, 3 sixteen.
// - Slot B result above the 14-bit limit counts one exceedance.
module fbtm_top
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  nrst_i,
    input  wire fbtm_pkg::fbtm_req_s    req_i,
    input  wire fbtm_pkg::fbtm_sample_s smp_i,
    output logic [15:0]                rd_data_o,
    output logic                       rd_valid_o,
    output logic [7:0]                 status_o
);
    import fbtm_pkg::*;

    // ------------------------------------------------------------
    // Target decode
    // ------------------------------------------------------------
    function automatic fbtm_count_t target(input logic [1:0] code);
        fbtm_count_t t;
        t = `FBTM_TGT_NEVER;
        unique case (code)
            2'h0: t = `FBTM_TGT_NEVER;
            2'h1: t = `FBTM_TGT_ONE;
            2'h2: t = `FBTM_TGT_FOUR;
            2'h3: t = `FBTM_TGT_SIXTEEN;
        endcase
        return t;
    endfunction : target

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] cfg_a;
    logic [15:0] cfg_b;
    logic [7:0]  flag;
    logic        clr;
    fbtm_count_t tgt_a;
    fbtm_count_t tgt_b;
    logic [7:0]  hit_v;
    logic [7:0]  set_v;
    fbtm_count_t cnt_v [8];

    assign clr   = req_i.rd && (req_i.addr == `FBTM_STATUS_OFS);
    assign tgt_a = target(cfg_a[`FBTM_TARGET_MSB:`FBTM_TARGET_LSB]);
    assign tgt_b = target(cfg_b[`FBTM_TARGET_MSB:`FBTM_TARGET_LSB]);

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cfg_a <= `FBTM_CFG_A_RST;
            cfg_b <= `FBTM_CFG_B_RST;
        end
        else if (req_i.wr)
        begin
            if (req_i.addr == `FBTM_CFG_A_OFS)
            begin
                cfg_a <= req_i.wdata;
            end
            if (req_i.addr == `FBTM_CFG_B_OFS)
            begin
                cfg_b <= req_i.wdata;
            end
        end
    end

    // Read data is registered, so it lands one cycle after the request.
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rd_data_o  <= `FBTM_STATUS_RST;
            rd_valid_o <= 1'b0;
        end
        else
        begin
            rd_valid_o <= req_i.rd;
            rd_data_o  <= 16'h0000;
            if (req_i.rd)
            begin
                unique case (req_i.addr)
                    `FBTM_STATUS_OFS: rd_data_o <= {8'h00, flag};
                    `FBTM_CFG_A_OFS:  rd_data_o <= cfg_a;
                    `FBTM_CFG_B_OFS:  rd_data_o <= cfg_b;
                    default:          rd_data_o <= 16'h0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Channel counters
    // ------------------------------------------------------------
    // Index 0..3 is slot A, 4..7 slot B, channel 1 lowest.
    // An exceedance in the cycle of a read is kept: set wins.
    genvar g;
    for (g = 0; g < 8; g++)
    begin : g_ch
        localparam bit SB = (g >= 4);
        logic [13:0]  limit;
        fbtm_count_t  tgt;
        fbtm_count_t  base;

        assign limit = SB ? cfg_b[`FBTM_LIMIT_MSB:0]
                          : cfg_a[`FBTM_LIMIT_MSB:0];
        assign tgt   = SB ? tgt_b : tgt_a;
        assign hit_v[g] = smp_i.valid && (smp_i.slot_b == SB)
                       && (smp_i.result[g % 4] > limit);
        assign base  = clr ? 5'h00 : cnt_v[g];
        assign set_v[g] = hit_v[g] && (tgt != `FBTM_TGT_NEVER)
                       && (base + 5'h01 == tgt);

        always_ff @(posedge ref_clk_i or negedge nrst_i)
        begin
            if (!nrst_i)
            begin
                cnt_v[g] <= 5'h00;
            end
            else if (hit_v[g] && base < tgt)
            begin
                cnt_v[g] <= base + 5'h01;
            end
            else
            begin
                cnt_v[g] <= base;
            end
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            flag <= 8'h00;
        end
        else
        begin
            flag <= (flag & {8{~clr}}) | set_v;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            status_o <= 8'h00;
        end
        else
        begin
            status_o <= (flag & {8{~clr}}) | set_v;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    b_clear_a:
    assert property (clr && set_v[7:4] == 4'h0 |=> flag[7:4] == 4'h0)
    else $error("slot B flags survived a status read");

    a_clear_a:
    assert property (clr && set_v[3:0] == 4'h0 |=> flag[3:0] == 4'h0)
    else $error("slot A flags survived a status read");

    b_map_a:
    assert property (clr |=> rd_valid_o && rd_data_o[7:4] == $past(flag[7:4]))
    else $error("slot B flags read back in wrong bits");

    a_map_a:
    assert property (clr |=> rd_data_o[3:0] == $past(flag[3:0])
                     && rd_data_o[15:8] == 8'h00)
    else $error("slot A flags read back in wrong bits");

    b_rise_a:
    assert property ($rose(flag[4]) |-> $past(hit_v[4]) && $past(tgt_b) != 0)
    else $error("slot B flag rose without an exceedance");

    a_rise_a:
    assert property ($rose(flag[0]) |-> $past(hit_v[0]) && $past(tgt_a) != 0)
    else $error("slot A flag rose without an exceedance");

    a_never_a:
    assert property (cfg_a[15:14] == 2'h0 |-> set_v[3:0] == 4'h0)
    else $error("slot A flag set with target code 0");

    b_sixteen_a:
    assert property ($past(cfg_b[15:14]) == 2'h3 && $rose(flag[4])
                     |-> $past(cnt_v[4]) == 5'h0f)
    else $error("slot B code 3 flag not at sixteenth count");

    a_count_a:
    assert property (hit_v[2] && !clr && cnt_v[2] < tgt_a
                     |=> cnt_v[2] == $past(cnt_v[2]) + 5'h01)
    else $error("slot A exceedance not counted");

    b_limit_a:
    assert property (smp_i.valid && smp_i.slot_b
                     && smp_i.result[1] <= cfg_b[13:0] |-> !hit_v[5])
    else $error("slot B result at or under limit counted");

    cnt_restart_a:
    assert property (clr |=> cnt_v[4] <= 5'h01 ##1 cnt_v[4] <= 5'h02)
    else $error("counter not restarted by status read");

    // A read and an exceedance in one cycle count from zero, so the
    // counter may already hold one right after the read.
    cnt_clear_a:
    assert property (clr && !hit_v[0] |=> cnt_v[0] == 5'h00)
    else $error("slot A counter not cleared by status read");

    cnt_sat_a:
    assert property (hit_v[0] && !clr && tgt_a != 5'h00
                     && cnt_v[0] == tgt_a |=> cnt_v[0] == $past(cnt_v[0]))
    else $error("slot A counter ran past its target");

    // ------------------------------------------------------------
    // Target checks
    // ------------------------------------------------------------
    b_never_a:
    assert property (cfg_b[15:14] == 2'h0 |-> set_v[7:4] == 4'h0)
    else $error("slot B flag set with target code 0");

    a_four_a:
    assert property ($past(cfg_a[15:14]) == 2'h2 && $rose(flag[2])
                     |-> $past(cnt_v[2]) == 5'h03)
    else $error("slot A code 2 flag not at fourth count");

    a_sixteen_a:
    assert property ($past(cfg_a[15:14]) == 2'h3 && $rose(flag[0])
                     |-> $past(cnt_v[0]) == 5'h0f)
    else $error("slot A code 3 flag not at sixteenth count");

    b_four_a:
    assert property ($past(cfg_b[15:14]) == 2'h2 && $rose(flag[4])
                     |-> $past(cnt_v[4]) == 5'h03)
    else $error("slot B code 2 flag not at fourth count");

    c3_rise_a:
    assert property ($rose(flag[6]) |-> $past(hit_v[6]) && $past(tgt_b) != 0)
    else $error("slot B channel 3 flag rose without an exceedance");

    a_limit_a:
    assert property (smp_i.valid && !smp_i.slot_b
                     && smp_i.result[1] <= cfg_a[13:0] |-> !hit_v[1])
    else $error("slot A result at or under limit counted");

    // ------------------------------------------------------------
    // Flag and register checks
    // ------------------------------------------------------------
    a_hold_a:
    assert property (!clr && flag[0] |=> flag[0])
    else $error("slot A flag dropped without a status read");

    b_hold_a:
    assert property (!clr && flag[4] |=> flag[4])
    else $error("slot B flag dropped without a status read");

    status_copy_a:
    assert property (status_o == flag)
    else $error("status output differs from the flags");

    rd_idle_a:
    assert property (!req_i.rd |=> !rd_valid_o && rd_data_o == 16'h0000)
    else $error("read data shown without a read");

    cfg_a_wr_a:
    assert property (req_i.wr && req_i.addr == `FBTM_CFG_A_OFS
                     |=> cfg_a == $past(req_i.wdata))
    else $error("slot A configuration write lost");

    cfg_b_wr_a:
    assert property (req_i.wr && req_i.addr == `FBTM_CFG_B_OFS
                     |=> cfg_b == $past(req_i.wdata))
    else $error("slot B configuration write lost");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    c_b_sixteen: cover property (tgt_b == 5'h10 ##1 $rose(flag[4]));
    c_set_clr:   cover property (clr && set_v != 8'h00);
    c_a_four:    cover property (tgt_a == 5'h04 && set_v[0]);
    c_a_sixteen: cover property (tgt_a == 5'h10 && set_v[0]);
    c_b_one:     cover property (tgt_b == 5'h01 && set_v[4]);

endmodule : fbtm_top

//--- sim/test_fbtm_top.sv
`timescale 1ns/1ps
`include "fbtm_regs.svh"

module test_fbtm_top;
    import fbtm_pkg::*;

    logic         ref_clk_i = 1'b0;
    logic         nrst_i    = 1'b0;
    fbtm_req_s    req_i     = '0;
    fbtm_sample_s smp_i     = '0;
    logic [15:0]  rd_data_o;
    logic         rd_valid_o;
    logic [7:0]   status_o;
    int           fails     = 0;
    int           cmp_count = 0;
    int           tgt_tab[4] = '{0, 1, 4, 16};

    always #5 ref_clk_i = ~ref_clk_i;

    fbtm_top fbtm_top_i
    (
        .ref_clk_i  (ref_clk_i),
        .nrst_i     (nrst_i),
        .req_i      (req_i),
        .smp_i      (smp_i),
        .rd_data_o  (rd_data_o),
        .rd_valid_o (rd_valid_o),
        .status_o   (status_o)
    );

    // ----------------------------------------------------------------
    // Port tasks
    // ----------------------------------------------------------------
    task chk(input string       name,
             input logic [15:0] exp,
             input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Each request ends with one idle edge, so a strobe is never lowered
    // and raised again in the same time step by two calls in a row.
    task rd(input logic [7:0] a, input logic [15:0] exp);
        req_i.rd   = 1'b1;
        req_i.addr = a;
        @(posedge ref_clk_i);
        #1;
        req_i.rd = 1'b0;
        chk("rd_valid_o", 16'h0001, {15'h0000, rd_valid_o});
        chk("rd_data_o", exp, rd_data_o);
        @(posedge ref_clk_i);
        #1;
    endtask : rd

    task wr(input logic [7:0] a, input logic [15:0] d);
        req_i.wr    = 1'b1;
        req_i.addr  = a;
        req_i.wdata = d;
        @(posedge ref_clk_i);
        #1;
        req_i.wr = 1'b0;
        @(posedge ref_clk_i);
        #1;
    endtask : wr

    // Channel 2 sits exactly on the limit, so strict comparison leaves it.
    task smp(input logic b, input int n);
        for (int i = 0; i < n; i++)
        begin
            smp_i.valid  = 1'b1;
            smp_i.slot_b = b;
            smp_i.result = {14'h0000, 14'h0065, 14'h0064, 14'h0065};
            @(posedge ref_clk_i);
            #1;
        end
        smp_i.valid = 1'b0;
        @(posedge ref_clk_i);
        #1;
    endtask : smp

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task test_regs;
        rd(`FBTM_STATUS_OFS, `FBTM_STATUS_RST);
        rd(`FBTM_CFG_A_OFS, `FBTM_CFG_A_RST);
        rd(`FBTM_CFG_B_OFS, `FBTM_CFG_B_RST);
        wr(`FBTM_STATUS_OFS, 16'hffff);
        rd(`FBTM_STATUS_OFS, 16'h0000);
        rd(8'h30, 16'h0000);
        $display("test_regs done");
    endtask : test_regs

    task test_target(input logic b, input int c);
        logic [7:0]  a;
        logic [7:0]  exp;
        logic [15:0] cfg;
        int          n;
        a   = b ? `FBTM_CFG_B_OFS : `FBTM_CFG_A_OFS;
        exp = (c == 0) ? 8'h00 : (b ? 8'h50 : 8'h05);
        cfg = {c[1:0], 14'h0064};
        n   = (c == 0) ? 20 : tgt_tab[c];
        wr(a, cfg);
        rd(a, cfg);
        smp(b, n - 1);
        chk("status_o early", 16'h0000, {8'h00, status_o});
        smp(b, 3);
        chk("status_o set", {8'h00, exp}, {8'h00, status_o});
        rd(`FBTM_STATUS_OFS, {8'h00, exp});
        rd(`FBTM_STATUS_OFS, 16'h0000);
        smp(b, (c == 0) ? 0 : n - 1);
        chk("status_o restart", 16'h0000, {8'h00, status_o});
        rd(`FBTM_STATUS_OFS, 16'h0000);
        $display("test_target slot %0d code %0d done", b, c);
    endtask : test_target

    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (5) @(posedge ref_clk_i);
        #1;
        nrst_i = 1'b1;
        test_regs();
        for (int s = 0; s < 2; s++)
        begin
            for (int c = 0; c < 4; c++)
            begin
                test_target(s[0], c);
            end
        end
        test_done();
    end

    // The whole sequence needs well under a thousand cycles.
    initial
    begin
        #100000;
        fails++;
        test_done();
    end

endmodule : test_fbtm_top
